/* verilog/pll_ld_map.svh */
`ifndef PLL_LD_MAP_SVH
`define PLL_LD_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define REG_LD_CFG_IDX   8'h07
`define REG_PUMP_IDX     8'h09
`define REG_PD_IDX       8'h0b
`define REG_OUTSEL_IDX   8'h0f
`define REG_STATUS_IDX   8'h12

// ****************************************************************
// Field positions
// ****************************************************************
`define LD_WINCNT_LSB    0
`define LD_EN_BIT        3
`define LD_WINSRC_BIT    6
`define LD_DIV_LSB       7
`define LD_SPEED_LSB     10
`define PUMP_DN_LSB      0
`define PUMP_UP_LSB      7
`define PUMP_OFS_LSB     14
`define PUMP_OFS_UP_BIT  21
`define PUMP_OFS_DN_BIT  22
`define PD_SLIP_LSB      7
`define OUT_SEL_LSB      0
`define OUT_SHARE_BIT    6
`define OUT_TEST_BIT     8
`define STATUS_LOCK_BIT  1

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define LD_CFG_RST       32'h0000_0000
`define PUMP_RST         32'h0000_1932
`define PD_RST           32'h0000_0000
`define OUTSEL_RST       32'h0000_0001
`define LD_CFG_MASK      32'h0000_0fcf
`define PUMP_MASK        32'h007f_ffff
`define PD_MASK          32'h0000_0180
`define OUTSEL_MASK      32'h0000_015f

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS    100
`define ANALOG_WIN_NS    10
`define ANALOG_WIN_RAW   (`ANALOG_WIN_NS / `CLK_PERIOD_NS)
`define ANALOG_WIN_CYC   ((`ANALOG_WIN_RAW < 1) ? 1 : `ANALOG_WIN_RAW)
`define SLIP_STEP_CYC    4
`define HITS_BASE        12'h010

`endif

/* verilog/pll_ld_pkg.sv */
package pll_ld_pkg;
    typedef enum {ST_IDLE, ST_OPEN} win_state_t;
    typedef logic [1:0] axi_resp_t;
endpackage

/* verilog/lock_window_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lock_window_if;
    logic       start;
    logic       cancel;
    logic       analog_sel;
    logic [1:0] speed;
    logic [2:0] div_sel;
    logic       expired;
    logic       timer_clk;
    modport ctrl  (output start, cancel, analog_sel, speed, div_sel, input expired, timer_clk);
    modport timer (input start, cancel, analog_sel, speed, div_sel, output expired, timer_clk);
endinterface
`default_nettype wire

/* verilog/lock_window_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_ld_map.svh"
module lock_window_timer (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    lock_window_if.timer win
);
    logic [2:0] presc_r;
    logic       half_tick;
    logic       timer_clk_r;
    logic       running_r;
    logic [7:0] cnt_r;
    logic [7:0] len_half;
    logic       done;

    // ****************************************************************
    // Lock-timer clock: half period is speed+1 system cycles
    // ****************************************************************
    assign half_tick = (presc_r == {1'b0, win.speed});

    always_ff @(posedge aclk) begin
        if (!aresetn || half_tick) begin
            presc_r <= 3'h0;
        end else begin
            presc_r <= presc_r + 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_clk_r <= 1'b0;
        end else if (half_tick) begin
            timer_clk_r <= ~timer_clk_r;
        end
    end

    assign win.timer_clk = timer_clk_r;

    // ****************************************************************
    // Window length in half periods: divide 0.5 is one half period
    // ****************************************************************
    assign len_half = 8'h01 << win.div_sel;

    // Free-running prescaler: first half period may be short by up to speed system cycles
    assign done = running_r && (win.analog_sel
                  ? (cnt_r + 8'h01 >= 8'(`ANALOG_WIN_CYC))
                  : (half_tick && (cnt_r + 8'h01 == len_half)));

    assign win.expired = done;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            running_r <= 1'b0;
            cnt_r     <= 8'h00;
        end else if (win.start) begin
            running_r <= 1'b1;
            cnt_r     <= 8'h00;
        end else if (win.cancel || done) begin
            running_r <= 1'b0;
        end else if (running_r && (win.analog_sel || half_tick)) begin
            cnt_r     <= cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* verilog/pll_lock_detect_and_pump_control.sv */
// Overview of operation
// - Select bit one: digital timer window
// - Window length: programmed lock-timer cycles
// - Divide codes 0..7: 0.5 to 64
// - Speed code 00 fastest, 11 slowest
// - Lock-timer clock visible on test output
// - Lock after programmed consecutive in-window hits
// - One miss clears lock immediately
// - Stays low until full count again
// - Lock flag readable as status bit
// - Output select one: lock on pin
// - Pin shows read data during reads
// - Window opens on first comparator edge
// - Window width from speed and divide
// - Slip boost past selectable phase threshold
// - Pump down and up gain fields
// - Gain code drives pump current outputs
// - Offset magnitude and direction fields
// - Select bit zero: fixed analog window
// - Global lock-detect enable bit
// - Either input may arrive first
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pll_ld_map.svh"
module pll_lock_detect_and_pump_control #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              ref_edge_pin,
    input  wire logic              div_edge_pin,
    input  wire logic              serial_read_active,
    input  wire logic              serial_read_data,
    output logic                   lock_or_serial_out_pin,
    output logic                   general_test_output,
    output logic                   lock_flag,
    output logic [6:0]             pump_down_gain,
    output logic [6:0]             pump_up_gain,
    output logic [6:0]             pump_offset,
    output logic                   pump_offset_up,
    output logic                   pump_offset_down,
    output logic [1:0]             slip_threshold,
    output logic                   slip_prevention
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [31:0]            ld_cfg_r;
    logic [31:0]            pump_r;
    logic [31:0]            pd_r;
    logic [31:0]            outsel_r;
    logic                   bvalid_r;
    pll_ld_pkg::axi_resp_t  bresp_r;
    logic                   rvalid_r;
    logic [31:0]            rdata_r;
    pll_ld_pkg::axi_resp_t  rresp_r;
    logic                   wr_hs;
    logic                   rd_hs;
    logic [ADDR_W-3:0]      wr_idx;
    logic [ADDR_W-3:0]      rd_idx;
    logic [31:0]            wmask;
    logic [1:0]             ref_sync_r;
    logic [1:0]             div_sync_r;
    logic                   ref_prev_r;
    logic                   div_prev_r;
    logic                   ref_rise;
    logic                   div_rise;
    pll_ld_pkg::win_state_t state_r;
    logic                   opener_ref_r;
    logic                   hit;
    logic                   miss;
    logic                   other_rise;
    logic [11:0]            hit_cnt_r;
    logic [11:0]            hits_needed;
    logic                   locked_r;
    logic                   ld_en;
    logic [7:0]             err_cnt_r;
    logic                   slip_r;
    logic                   pin_r;
    logic                   test_r;
    logic                   pin_to_serial;
    lock_window_if win ();
    assign ld_en = ld_cfg_r[`LD_EN_BIT];

    // ****************************************************************
    // AXI4-Lite write: address and data taken together
    // ****************************************************************
    assign wr_hs         = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wr_hs;
    assign s_axi_wready  = wr_hs;
    assign wr_idx        = s_axi_awaddr[ADDR_W-1:2];
    assign wmask         = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ld_cfg_r <= `LD_CFG_RST;
            pump_r   <= `PUMP_RST;
            pd_r     <= `PD_RST;
            outsel_r <= `OUTSEL_RST;
        end else if (wr_hs) begin
            case (wr_idx)
                (ADDR_W-2)'(`REG_LD_CFG_IDX):
                    ld_cfg_r <= ((ld_cfg_r & ~wmask) | (s_axi_wdata & wmask)) & `LD_CFG_MASK;
                (ADDR_W-2)'(`REG_PUMP_IDX):
                    pump_r <= ((pump_r & ~wmask) | (s_axi_wdata & wmask)) & `PUMP_MASK;
                (ADDR_W-2)'(`REG_PD_IDX):
                    pd_r <= ((pd_r & ~wmask) | (s_axi_wdata & wmask)) & `PD_MASK;
                (ADDR_W-2)'(`REG_OUTSEL_IDX):
                    outsel_r <= ((outsel_r & ~wmask) | (s_axi_wdata & wmask)) & `OUTSEL_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else if (wr_hs) begin
            bvalid_r <= 1'b1;
            case (wr_idx)
                (ADDR_W-2)'(`REG_LD_CFG_IDX), (ADDR_W-2)'(`REG_PUMP_IDX), (ADDR_W-2)'(`REG_PD_IDX),
                (ADDR_W-2)'(`REG_OUTSEL_IDX), (ADDR_W-2)'(`REG_STATUS_IDX): bresp_r <= 2'b00;
                default: bresp_r <= 2'b10;
            endcase
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ****************************************************************
    // AXI4-Lite read
    // ****************************************************************
    assign rd_hs         = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign rd_idx        = s_axi_araddr[ADDR_W-1:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'b00;
        end else if (rd_hs) begin
            rvalid_r <= 1'b1;
            rresp_r  <= 2'b00;
            case (rd_idx)
                (ADDR_W-2)'(`REG_LD_CFG_IDX): rdata_r <= ld_cfg_r;
                (ADDR_W-2)'(`REG_PUMP_IDX):   rdata_r <= pump_r;
                (ADDR_W-2)'(`REG_PD_IDX):     rdata_r <= pd_r;
                (ADDR_W-2)'(`REG_OUTSEL_IDX): rdata_r <= outsel_r;
                (ADDR_W-2)'(`REG_STATUS_IDX): rdata_r <= 32'(locked_r) << `STATUS_LOCK_BIT;
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // ****************************************************************
    // Comparator edge capture
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_sync_r <= 2'b00;
            div_sync_r <= 2'b00;
            ref_prev_r <= 1'b0;
            div_prev_r <= 1'b0;
        end else begin
            ref_sync_r <= {ref_sync_r[0], ref_edge_pin};
            div_sync_r <= {div_sync_r[0], div_edge_pin};
            ref_prev_r <= ref_sync_r[1];
            div_prev_r <= div_sync_r[1];
        end
    end

    assign ref_rise = ref_sync_r[1] && !ref_prev_r;
    assign div_rise = div_sync_r[1] && !div_prev_r;

    // ****************************************************************
    // Window control
    // ****************************************************************
    assign win.analog_sel = !ld_cfg_r[`LD_WINSRC_BIT];
    assign win.speed      = ld_cfg_r[`LD_SPEED_LSB +: 2];
    assign win.div_sel    = ld_cfg_r[`LD_DIV_LSB +: 3];
    assign win.start      = ld_en && (state_r == pll_ld_pkg::ST_IDLE)
                            && (ref_rise ^ div_rise);

    // The opposite input closes the window as a hit, timer expiry as a miss; either may lead
    assign other_rise = opener_ref_r ? div_rise : ref_rise;
    assign win.cancel = (state_r == pll_ld_pkg::ST_OPEN) && other_rise;
    assign hit  = ld_en && (((state_r == pll_ld_pkg::ST_IDLE) && ref_rise && div_rise)
                            || win.cancel);
    assign miss = ld_en && (state_r == pll_ld_pkg::ST_OPEN) && !other_rise && win.expired;
    lock_window_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .win     (win.timer)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn || !ld_en) begin
            state_r      <= pll_ld_pkg::ST_IDLE;
            opener_ref_r <= 1'b0;
        end else begin
            case (state_r)
                pll_ld_pkg::ST_IDLE: begin
                    if (win.start) begin
                        state_r      <= pll_ld_pkg::ST_OPEN;
                        opener_ref_r <= ref_rise;
                    end
                end
                pll_ld_pkg::ST_OPEN: begin
                    if (hit || miss) begin
                        state_r <= pll_ld_pkg::ST_IDLE;
                    end
                end
                default: state_r <= pll_ld_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Lock declaration
    // ****************************************************************
    assign hits_needed = `HITS_BASE << ld_cfg_r[`LD_WINCNT_LSB +: 3];
    always_ff @(posedge aclk) begin
        if (!aresetn || !ld_en) begin
            hit_cnt_r <= 12'h000;
            locked_r  <= 1'b0;
        end else if (miss) begin
            hit_cnt_r <= 12'h000;
            locked_r  <= 1'b0;
        end else if (hit) begin
            if (hit_cnt_r + 12'h001 >= hits_needed) begin
                locked_r <= 1'b1;
            end else begin
                hit_cnt_r <= hit_cnt_r + 12'h001;
            end
        end
    end

    assign lock_flag = locked_r;

    // ****************************************************************
    // Slip prevention: boost while the open window outlasts threshold
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || state_r != pll_ld_pkg::ST_OPEN) begin
            err_cnt_r <= 8'h00;
        end else if (err_cnt_r != 8'hff) begin
            err_cnt_r <= err_cnt_r + 8'h01;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slip_r <= 1'b0;
        end else begin
            slip_r <= (state_r == pll_ld_pkg::ST_OPEN) && !hit && !miss
                      && (err_cnt_r >= 8'((32'(pd_r[`PD_SLIP_LSB +: 2]) + 1) * `SLIP_STEP_CYC));
        end
    end

    assign slip_prevention = slip_r;
    assign slip_threshold  = pd_r[`PD_SLIP_LSB +: 2];

    // ****************************************************************
    // Pump fields
    // ****************************************************************
    // Code 50 gives 1 mA per pump; analog side scales, so codes pass raw
    assign pump_down_gain   = pump_r[`PUMP_DN_LSB +: 7];
    assign pump_up_gain     = pump_r[`PUMP_UP_LSB +: 7];
    assign pump_offset      = pump_r[`PUMP_OFS_LSB +: 7];
    assign pump_offset_up   = pump_r[`PUMP_OFS_UP_BIT];
    assign pump_offset_down = pump_r[`PUMP_OFS_DN_BIT];

    // ****************************************************************
    // Shared pin and test output
    // ****************************************************************
    assign pin_to_serial = !outsel_r[`OUT_SHARE_BIT] && serial_read_active;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_r <= 1'b0;
        end else if (pin_to_serial || outsel_r[`OUT_SEL_LSB +: 5] != 5'h01) begin
            pin_r <= serial_read_data;
        end else begin
            pin_r <= locked_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_r <= 1'b0;
        end else begin
            test_r <= outsel_r[`OUT_TEST_BIT] && win.timer_clk;
        end
    end

    assign lock_or_serial_out_pin = pin_r;
    assign general_test_output    = test_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_miss_clears_lock: assert property (miss |=> !locked_r && hit_cnt_r == 12'h000)
        else $error("lock not cleared after miss");
    a_lock_needs_count: assert property ($rose(locked_r) |-> $past(hit) && $past(hit_cnt_r) + 12'h001 >= $past(hits_needed))
        else $error("lock rose without full hit count");
    a_low_until_count: assert property (!locked_r && !(hit && hit_cnt_r + 12'h001 >= hits_needed) |=> !locked_r)
        else $error("lock rose early");
    a_disable_clears: assert property (!ld_en |=> !locked_r && hit_cnt_r == 12'h000 && state_r == pll_ld_pkg::ST_IDLE)
        else $error("disable did not clear lock state");
    a_window_opens: assert property (ld_en && state_r == pll_ld_pkg::ST_IDLE && (ref_rise ^ div_rise) |=> state_r == pll_ld_pkg::ST_OPEN)
        else $error("window did not open on first edge");
    a_window_bounded: assert property ($rose(state_r == pll_ld_pkg::ST_OPEN) |-> ##[1:600] state_r == pll_ld_pkg::ST_IDLE)
        else $error("window never closed");
    a_pin_lock: assert property (outsel_r[`OUT_SEL_LSB +: 5] == 5'h01 && !pin_to_serial |=> pin_r == $past(locked_r))
        else $error("pin does not show lock");
    a_pin_serial: assert property (pin_to_serial |=> pin_r == $past(serial_read_data))
        else $error("pin does not show read data");
    a_status_read: assert property (rd_hs && rd_idx == (ADDR_W-2)'(`REG_STATUS_IDX) |=> s_axi_rvalid && s_axi_rdata[`STATUS_LOCK_BIT] == $past(locked_r))
        else $error("status bit does not match lock");
    a_write_resp: assert property (wr_hs |=> bvalid_r)
        else $error("no write response");
    c_lock_reached: cover property ($rose(locked_r));
    c_lock_lost: cover property (locked_r && miss);
    c_digital_window: cover property (!win.analog_sel && win.expired);
    c_serial_read: cover property (pin_to_serial && locked_r);
endmodule
`default_nettype wire

/* testbench/pd_edge_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Comparator edge source
// ****************************************
module pd_edge_model (
    input  wire logic aclk,
    output logic      ref_edge,
    output logic      div_edge
);
    initial begin
        ref_edge = 1'b0;
        div_edge = 1'b0;
    end
    // Call at a rising edge; long gap keeps windows apart
    task automatic pair(input int ofs, input bit div_first);
        if (div_first)
            div_edge <= 1'b1;
        else
            ref_edge <= 1'b1;
        repeat (ofs) @(posedge aclk);
        if (div_first)
            ref_edge <= 1'b1;
        else
            div_edge <= 1'b1;
        repeat (2) @(posedge aclk);
        ref_edge <= 1'b0;
        div_edge <= 1'b0;
        repeat (30) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_ld_map.svh"
module testbench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sra, srd;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r, thr;
    logic        awready, wready, bvalid, arready, rvalid, pin, tst, lock, po_up, po_dn, slip, re, de;
    logic [6:0]  pdn, pup, pofs;
    int          err_count, n_checks, cyc;
    pd_edge_model i_pd_edge_model (.aclk(aclk), .ref_edge(re), .div_edge(de));
    pll_lock_detect_and_pump_control i_pll_lock_detect_and_pump_control (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ref_edge_pin(re), .div_edge_pin(de), .serial_read_active(sra),
        .serial_read_data(srd), .lock_or_serial_out_pin(pin), .general_test_output(tst),
        .lock_flag(lock), .pump_down_gain(pdn), .pump_up_gain(pup), .pump_offset(pofs),
        .pump_offset_up(po_up), .pump_offset_down(po_dn), .slip_threshold(thr), .slip_prevention(slip));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    function automatic logic [7:0] ba(input logic [7:0] i);
        return {i[5:0], 2'b00};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (awready !== 1'b1 || wready !== 1'b1) @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(posedge aclk);
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic hits(input int n, input int ofs, input bit swap);
        repeat (n) i_pd_edge_model.pair(ofs, swap);
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, well above the roughly 1800 cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, sra, srd} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ba(`REG_PUMP_IDX));
        chk(d, 32'h0000_1932);
        rd(ba(`REG_OUTSEL_IDX));
        chk(d, 32'h0000_0001);
        rd(8'h40);
        chk({d[29:0], r}, 32'h0000_0002);
        // Offset kept at a fifth of the gain, safe with the analog window
        wr(ba(`REG_PUMP_IDX), 32'h0042_9932);
        chk({po_dn, po_up, pofs, pup, pdn}, 32'h0042_9932);
        wr(ba(`REG_PD_IDX), 32'h0000_0180);
        chk(thr, 32'h3);
        $display("registers done");
        wr(ba(`REG_LD_CFG_IDX), 32'h0000_0148);
        hits(15, 1, 1'b0);
        chk(lock, 32'h0);
        hits(1, 1, 1'b0);
        chk({pin, lock}, 32'h3);
        rd(ba(`REG_STATUS_IDX));
        chk(d[1], 32'h1);
        sra <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(pin, 32'h0);
        sra <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(pin, 32'h1);
        $display("lock done");
        hits(1, 12, 1'b0);
        chk(lock, 32'h0);
        hits(15, 1, 1'b1);
        chk(lock, 32'h0);
        hits(1, 1, 1'b1);
        chk(lock, 32'h1);
        wr(ba(`REG_LD_CFG_IDX), 32'h0000_0008);
        hits(1, 3, 1'b0);
        chk(lock, 32'h0);
        hits(16, 0, 1'b0);
        chk(lock, 32'h1);
        // Fastest timer speed: the test output toggles every cycle
        wr(ba(`REG_OUTSEL_IDX), 32'h0000_0101);
        @(negedge aclk) d = tst;
        @(negedge aclk) chk(tst, !d[0]);
        wr(ba(`REG_OUTSEL_IDX), 32'h0000_0001);
        // Divide code 5 gives 32 cycles, too short for a 40 cycle offset
        wr(ba(`REG_LD_CFG_IDX), 32'h0000_02c8);
        fork
            i_pd_edge_model.pair(40, 1'b0);
            begin
                repeat (10) @(negedge aclk);
                chk(slip, 32'h0);
                repeat (15) @(negedge aclk);
                chk(slip, 32'h1);
            end
        join
        chk(lock, 32'h0);
        wr(ba(`REG_LD_CFG_IDX), 32'h0000_0000);
        repeat (2) @(posedge aclk);
        chk({tst, pin, lock}, 32'h0);
        $display("window done");
        finish_test();
    end
endmodule
`default_nettype wire
